// ### dv/pfp_flash_port_asserts.sv
// checker: port properties of the flash program port
`timescale 1ns/1ps
module pfp_flash_port_asserts
#(
  parameter int unsigned DEPTH = 16
)
(
  // clock and pins
  input wire logic clk,
  input wire logic sys_rst,
  input wire pfp_pkg::pfp_ctrl_t ctrl,
  input wire logic [15:0] addr,
  input wire pfp_pkg::pfp_tbl_req_t tbl_req,
  // device answers
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic tbl_to_internal,
  input wire logic tbl_to_external,
  input wire logic prog_mode,
  input wire logic lock_active,
  input wire logic crypt_active,
  input wire logic [7:0] sec_reg
);
  import pfp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic quiet, is_rd, is_ers;
  // decoded read and erase pin sets
  assign quiet = prog_mode && !ctrl.mode_ctrl_pin_b && !ctrl.mode_ctrl_pin_c && !ctrl.mode_ctrl_pin_d;
  assign is_rd = quiet && !ctrl.erase_select_pin && !ctrl.chip_select_n && !ctrl.output_gate_n
    && ctrl.vpp == PFP_VPP_LOGIC;
  assign is_ers = quiet && ctrl.erase_select_pin && !ctrl.chip_select_n && ctrl.output_gate_n
    && ctrl.vpp == PFP_VPP_ERASE && !addr[0];
  sequence rd2_s;
    is_rd ##1 is_rd;
  endsequence
  sequence lrd_s;
    is_rd && lock_active ##1 is_rd;
  endsequence
  // a cycle in programming mode that must not write, still in the mode next cycle
  sequence idle_s;
    prog_mode && (!quiet || ctrl.chip_select_n && ctrl.output_gate_n) ##1 prog_mode;
  endsequence
  no_write_a:
    assert property (idle_s |-> $stable(sec_reg)) else $error("inhibited cycle changed security");
  route_one_a:
    assert property (tbl_req.valid |-> tbl_to_internal != tbl_to_external) else $error("table read routed badly");
  prog_mode_a:
    assert property (prog_mode == (ctrl.rst_pin && !ctrl.addr_latch_strobe && ctrl.program_store_strobe_n))
    else $error("mode decode wrong");
  read_drive_a:
    assert property (rd2_s |-> data_oe) else $error("read not driven");
  lock_read_a:
    assert property (lrd_s |-> data_out == PFP_INVALID_BYTE) else $error("locked read leaked");
  gate_float_a:
    assert property (ctrl.output_gate_n |-> !data_oe) else $error("bus driven with gate high");
  erase_all_a:
    assert property (is_ers |=> !lock_active && !crypt_active && (!prog_mode || sec_reg == PFP_SEC_RESET))
    else $error("erase left bits low");
  sec_hidden_a:
    assert property (!prog_mode |-> sec_reg == 8'h00) else $error("security visible");
  lock_sticky_a:
    assert property (lock_active && !is_ers |=> lock_active) else $error("lock cleared");
  int_table_a:
    assert property (tbl_req.valid && tbl_req.from_internal && tbl_req.addr < DEPTH |-> tbl_to_internal)
    else $error("internal read blocked");
endmodule // pfp_flash_port_asserts
bind pfp_flash_port pfp_flash_port_asserts #(.DEPTH(DEPTH)) i_pfp_flash_port_asserts (.clk(clk),
  .sys_rst(sys_rst), .ctrl(ctrl), .addr(addr), .tbl_req(tbl_req), .data_out(data_out), .data_oe(data_oe),
  .tbl_to_internal(tbl_to_internal), .tbl_to_external(tbl_to_external), .prog_mode(prog_mode),
  .lock_active(lock_active),
  .crypt_active(crypt_active), .sec_reg(sec_reg));

// ### dv/pfp_prog_model.sv
// model: parallel programmer driving the flash port pins
`timescale 1ns/1ps
module pfp_prog_model
(
  // bench commands
  input wire pfp_pkg::pfp_op_t op,
  input wire logic [1:0] mode,
  input wire logic [15:0] a,
  input wire logic [7:0] d,
  // device pins
  output pfp_pkg::pfp_ctrl_t ctrl,
  output logic [15:0] addr,
  output logic [7:0] data_in
);
  import pfp_pkg::*;
  // mode 1 adds a stray pin, mode 2 leaves programming mode
  always_comb
  begin
    ctrl = '0;
    ctrl.rst_pin = (mode != 2'h2);
    ctrl.program_store_strobe_n = 1'b1;
    ctrl.mode_ctrl_pin_b = (mode == 2'h1);
    ctrl.chip_select_n = op inside {PFP_OP_PROG_VERIFY, PFP_OP_ERASE_VERIFY, PFP_OP_INHIBIT};
    ctrl.output_gate_n = op inside {PFP_OP_OUT_DIS, PFP_OP_PROGRAM, PFP_OP_ERASE, PFP_OP_INHIBIT};
    ctrl.erase_select_pin = op inside {PFP_OP_ERASE, PFP_OP_ERASE_VERIFY};
    ctrl.vpp = ctrl.erase_select_pin ? PFP_VPP_ERASE :
      (op inside {PFP_OP_PROGRAM, PFP_OP_PROG_VERIFY, PFP_OP_INHIBIT}) ? PFP_VPP_PROG : PFP_VPP_LOGIC;
    // erase wants A0 low and all ones
    addr = (op == PFP_OP_ERASE) ? {a[15:1], 1'b0} : a;
    // released data lines show the inverse, not a stale byte
    data_in = (op == PFP_OP_ERASE) ? PFP_ERASED_BYTE : (op == PFP_OP_PROGRAM) ? d : ~d;
  end
endmodule // pfp_prog_model

// ### dv/tb.sv
// testbench: programmer sequences against the flash port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
  import pfp_pkg::*;
  logic clk = 0, sys_rst = 1, data_oe, ti, te, prog_mode, lock_active, crypt_active;
  logic [1:0] mode = 0;
  logic [15:0] ca = 0, addr;
  logic [7:0] cd = 0, data_in, data_out, tbl_data, sec_reg;
  pfp_op_t cmd = PFP_OP_OUT_DIS;
  pfp_ctrl_t ctrl;
  pfp_tbl_req_t tbl_req = '0;
  int err_total = 0, check_count = 0, cyc = 0;
  pfp_prog_model i_pfp_prog_model (.op(cmd), .mode(mode), .a(ca), .d(cd), .ctrl(ctrl), .addr(addr),
    .data_in(data_in));
  pfp_flash_port #(.DEPTH(16)) i_pfp_flash_port (.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .tbl_req(tbl_req), .tbl_data(tbl_data),
    .tbl_to_internal(ti), .tbl_to_external(te), .prog_mode(prog_mode), .lock_active(lock_active),
    .crypt_active(crypt_active), .sec_reg(sec_reg));
  always #50 clk = ~clk;
  // hang guard: tests need well under this
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_total++;
      print_verdict;
    end
  end
  task automatic op(input pfp_op_t o, input logic [15:0] a, input logic [7:0] d);
    cmd = o;
    ca = a;
    cd = d;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input pfp_op_t o, input logic [15:0] a, input logic [7:0] e);
    op(o, a, 8'h00);
    `CHK("data_out", e, data_out)
  endtask
  task automatic t_erase;
    op(PFP_OP_ERASE, 16'h0001, 8'h00);
    for (int i = 0; i < 16; i++) rd(PFP_OP_ERASE_VERIFY, 16'(i), 8'hff);
    rd(PFP_OP_ERASE_VERIFY, PFP_SEC_ADDR, 8'hff);
    $display("erase test done");
  endtask
  task automatic t_program;
    op(PFP_OP_PROGRAM, 16'h0003, 8'ha5);
    rd(PFP_OP_PROG_VERIFY, 16'h0003, 8'ha5);
    op(PFP_OP_PROGRAM, 16'h0003, 8'h3c);
    rd(PFP_OP_READ, 16'h0003, 8'h24);
    op(PFP_OP_INHIBIT, 16'h0003, 8'hff); // released lines show 00, so a stray write would show
    mode = 2'h1;
    op(PFP_OP_PROGRAM, 16'h0003, 8'h00);
    mode = 2'h0;
    rd(PFP_OP_READ, 16'h0003, 8'h24);
    rd(PFP_OP_READ, 16'h0003, 8'h24);
    `CHK("data_oe", 1'b1, data_oe)
    op(PFP_OP_OUT_DIS, 16'h0003, 8'h00);
    `CHK("data_oe", 1'b0, data_oe)
    $display("program test done");
  endtask
  task automatic t_table;
    mode = 2'h2;
    tbl_req = '{valid: 1'b1, from_internal: 1'b0, addr: 16'h0003};
    op(PFP_OP_OUT_DIS, 16'h0, 8'h00);
    `CHK("to_internal", 1'b1, ti)
    mode = 2'h0;
    op(PFP_OP_PROGRAM, PFP_SEC_ADDR, 8'hfd);
    rd(PFP_OP_READ, PFP_SEC_ADDR, 8'hfd);
    mode = 2'h2;
    op(PFP_OP_OUT_DIS, 16'h0, 8'h00);
    `CHK("to_external", 1'b1, te)
    `CHK("to_internal", 1'b0, ti)
    `CHK("sec_reg", 8'h00, sec_reg)
    tbl_req.from_internal = 1'b1;
    op(PFP_OP_OUT_DIS, 16'h0, 8'h00);
    `CHK("tbl_data", 8'h24, tbl_data)
    tbl_req.addr = 16'h0013;
    op(PFP_OP_OUT_DIS, 16'h0, 8'h00);
    `CHK("to_external", 1'b1, te)
    `CHK("to_internal", 1'b0, ti)
    tbl_req = '0;
    mode = 2'h0;
    $display("table test done");
  endtask
  // reset clears the read path but keeps the nonvolatile cells
  task automatic t_reset;
    rd(PFP_OP_READ, PFP_SEC_ADDR, 8'hfd);
    tbl_req = '{valid: 1'b1, from_internal: 1'b1, addr: 16'h0003};
    sys_rst = 1;
    op(PFP_OP_OUT_DIS, 16'h0, 8'h00);
    op(PFP_OP_OUT_DIS, 16'h0, 8'h00);
    `CHK("data_out", 8'h00, data_out)
    `CHK("tbl_data", 8'h00, tbl_data)
    tbl_req = '0;
    sys_rst = 0;
    rd(PFP_OP_READ, 16'h0003, 8'h24);
    rd(PFP_OP_READ, PFP_SEC_ADDR, 8'hfd);
    $display("reset test done");
  endtask
  task automatic t_crypt;
    op(PFP_OP_PROGRAM, PFP_SEC_ADDR, 8'hfb);
    `CHK("crypt_active", 1'b1, crypt_active)
    rd(PFP_OP_READ, 16'h0003, 8'h24 ^ PFP_CRYPT_KEY ^ 8'h03);
    $display("crypt test done");
  endtask
  task automatic t_lock;
    t_erase;
    op(PFP_OP_PROGRAM, PFP_SEC_ADDR, 8'hfe);
    `CHK("lock_active", 1'b1, lock_active)
    rd(PFP_OP_READ, 16'h0003, PFP_INVALID_BYTE);
    rd(PFP_OP_READ, PFP_SEC_ADDR, PFP_INVALID_BYTE);
    // a write while locked must not land; the core path still sees the cell
    op(PFP_OP_PROGRAM, 16'h0003, 8'h00);
    tbl_req = '{valid: 1'b1, from_internal: 1'b1, addr: 16'h0003};
    op(PFP_OP_OUT_DIS, 16'h0, 8'h00);
    `CHK("tbl_data", 8'hff, tbl_data)
    tbl_req = '0;
    t_erase;
    `CHK("lock_active", 1'b0, lock_active)
    $display("lock test done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 0;
    t_erase;
    t_program;
    t_table;
    t_reset;
    t_crypt;
    t_lock;
    print_verdict;
  end
endmodule // tb

// ### logic/pfp_flash_port.sv
// module: parallel programming port of the on-chip program flash
`timescale 1ns/1ps
// ------------------------------------------------------------
// Operation
// - ports carry sixteen-bit address, eight-bit data
// - read mode drives stored byte out
// - locked part returns invalid read data
// - output gate high floats data bus
// - erase sets every cell and bit
// - both selects high: no write
// - security register only in programming mode
// - programmed security bit sticks until erase
// - security register at top address
// - lock denies flash and security access
// - external code table reads stay external
// - internal code reads every flash cell
// - restriction bit one: no limit
// - encryption encodes port zero output
// ------------------------------------------------------------
module pfp_flash_port
#(
  parameter int unsigned DEPTH = pfp_pkg::PFP_FLASH_DEPTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control pins
  input wire pfp_pkg::pfp_ctrl_t ctrl,
  // address bus, upper and lower ports
  input wire logic [pfp_pkg::PFP_ADDR_W-1:0] addr,
  // data bus on port zero, three signals
  input wire logic [pfp_pkg::PFP_DATA_W-1:0] data_in,
  output logic [pfp_pkg::PFP_DATA_W-1:0] data_out,
  output logic data_oe,
  // core side table read
  input wire pfp_pkg::pfp_tbl_req_t tbl_req,
  output logic [pfp_pkg::PFP_DATA_W-1:0] tbl_data,
  output logic tbl_to_internal,
  output logic tbl_to_external,
  // status
  output logic prog_mode,
  output logic lock_active,
  output logic crypt_active,
  output logic [pfp_pkg::PFP_DATA_W-1:0] sec_reg
);
  import pfp_pkg::*;

  localparam int unsigned IDX_W = $clog2(DEPTH);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0] sec;
    logic [7:0] dout;
    logic oe;
    logic [7:0] tdat;
  } pfp_state_t;

  pfp_state_t st;
  pfp_state_t next_st;
  pfp_op_t op;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] tidx;
  logic sec_hit;
  logic in_flash;
  logic locked;
  logic [7:0] raw;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  pfp_mode_decode u_dec
  (
    .ctrl(ctrl),
    .addr_bit0(addr[0]),
    .op(op),
    .prog_mode(prog_mode)
  );

  // gate shares the array depth; table addresses past it go outside
  pfp_tbl_gate #(.DEPTH(DEPTH)) u_tbl
  (
    .req(tbl_req),
    .tbl_restrict(st.sec[PFP_SEC_TBL_RESTRICT]),
    .to_internal(tbl_to_internal),
    .to_external(tbl_to_external)
  );

  assign idx = addr[IDX_W-1:0];
  assign tidx = tbl_req.addr[IDX_W-1:0];
  assign sec_hit = (addr == PFP_SEC_ADDR);
  assign in_flash = (addr < PFP_ADDR_W'(DEPTH));
  assign locked = ~st.sec[PFP_SEC_LOCK];
  // unmapped bytes read as erased, like a blank cell
  assign raw = sec_hit ? st.sec : (in_flash ? st.mem[idx] : PFP_ERASED_BYTE);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.oe = 1'b0;
    next_st.dout = st.dout;
    // core fetch path ignores lock; only the programmer path is guarded
    next_st.tdat = tbl_to_internal ? st.mem[tidx] : 8'h00;
    case (op)
      PFP_OP_READ, PFP_OP_PROG_VERIFY, PFP_OP_ERASE_VERIFY:
      begin
        next_st.oe = 1'b1;
        if (locked)
          next_st.dout = PFP_INVALID_BYTE;
        else if (st.sec[PFP_SEC_CRYPT] == 1'b0)
          next_st.dout = pfp_encrypt(raw, addr);
        else
          next_st.dout = raw;
      end
      PFP_OP_PROGRAM:
      begin
        if (!locked)
        begin
          if (sec_hit)
            next_st.sec = st.sec & data_in;
          else if (in_flash)
            next_st.mem[idx] = st.mem[idx] & data_in;
        end
      end
      PFP_OP_ERASE:
      begin
        // whole chip and security to ones
        for (int i = 0; i < DEPTH; i++)
          next_st.mem[i] = PFP_ERASED_BYTE;
        next_st.sec = PFP_SEC_RESET;
      end
      PFP_OP_OUT_DIS, PFP_OP_INHIBIT: next_st.oe = 1'b0;
      default: next_st.oe = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // registers; flash keeps contents across reset (nonvolatile)
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st.mem <= next_st.mem;
      st.sec <= next_st.sec;
      st.dout <= 8'h00;
      st.oe <= 1'b0;
      st.tdat <= 8'h00;
    end
    else
      st <= next_st;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign data_out = st.dout;
  // gate pin high forces float immediately
  assign data_oe = st.oe & ~ctrl.output_gate_n & prog_mode;
  assign tbl_data = st.tdat;
  assign lock_active = locked;
  assign crypt_active = ~st.sec[PFP_SEC_CRYPT];
  // security visible only in programming mode
  assign sec_reg = prog_mode ? st.sec : 8'h00;

endmodule // pfp_flash_port

// ### logic/pfp_mode_decode.sv
// module: maps programming-mode pin levels to one operation
`timescale 1ns/1ps
module pfp_mode_decode
(
  // pins
  input wire pfp_pkg::pfp_ctrl_t ctrl,
  input wire logic addr_bit0,
  // decoded operation
  output pfp_pkg::pfp_op_t op,
  output logic prog_mode
);
  import pfp_pkg::*;

  logic upper_ok;

  // programming mode needs reset high, latch strobe low, store strobe high
  // programmer pin setup
  assign prog_mode = ctrl.rst_pin & ~ctrl.addr_latch_strobe & ctrl.program_store_strobe_n;
  assign upper_ok = prog_mode & ~ctrl.mode_ctrl_pin_b & ~ctrl.mode_ctrl_pin_c & ~ctrl.mode_ctrl_pin_d;

  // table lookup; anything unlisted falls to inhibit
  always_comb
  begin
    op = PFP_OP_INHIBIT;
    if (upper_ok)
    begin
      case ({ctrl.erase_select_pin, ctrl.chip_select_n, ctrl.output_gate_n})
        3'b000: op = (ctrl.vpp == PFP_VPP_LOGIC) ? PFP_OP_READ : PFP_OP_INHIBIT;
        3'b001:
        begin
          if (ctrl.vpp == PFP_VPP_PROG)
            op = PFP_OP_PROGRAM;
          else if (ctrl.vpp == PFP_VPP_LOGIC)
            op = PFP_OP_OUT_DIS;
          else
            op = PFP_OP_INHIBIT;
        end
        3'b010: op = (ctrl.vpp == PFP_VPP_PROG) ? PFP_OP_PROG_VERIFY : PFP_OP_INHIBIT;
        3'b101: op = (ctrl.vpp == PFP_VPP_ERASE && !addr_bit0) ? PFP_OP_ERASE : PFP_OP_INHIBIT;
        3'b110: op = (ctrl.vpp == PFP_VPP_ERASE) ? PFP_OP_ERASE_VERIFY : PFP_OP_INHIBIT;
        default: op = PFP_OP_INHIBIT;
      endcase
    end
  end

endmodule // pfp_mode_decode

// ### logic/pfp_pkg.sv
// package: constants and carriers for the parallel flash program port
package pfp_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int unsigned PFP_ADDR_W = 16;
  localparam int unsigned PFP_DATA_W = 8;
  localparam int unsigned PFP_FLASH_DEPTH = 4096;
  localparam logic [15:0] PFP_SEC_ADDR = 16'hffff;
  localparam logic [7:0] PFP_ERASED_BYTE = 8'hff;
  localparam logic [7:0] PFP_INVALID_BYTE = 8'h00;
  localparam logic [7:0] PFP_CRYPT_KEY = 8'h5a;

  // ------------------------------------------------------------
  // security register field positions
  // ------------------------------------------------------------
  localparam int unsigned PFP_SEC_LOCK = 0;
  localparam int unsigned PFP_SEC_TBL_RESTRICT = 1;
  localparam int unsigned PFP_SEC_CRYPT = 2;
  localparam logic [7:0] PFP_SEC_RESET = 8'hff;

  // ------------------------------------------------------------
  // programming-voltage levels as decoded by the analog front end
  // ------------------------------------------------------------
  typedef enum logic [1:0] {PFP_VPP_LOGIC, PFP_VPP_PROG, PFP_VPP_ERASE, PFP_VPP_LOW} pfp_vpp_t;

  // operations of the port
  typedef enum logic [2:0] {
    PFP_OP_INHIBIT, PFP_OP_READ, PFP_OP_OUT_DIS, PFP_OP_PROGRAM,
    PFP_OP_PROG_VERIFY, PFP_OP_ERASE, PFP_OP_ERASE_VERIFY
  } pfp_op_t;

  // control pin group; ops act on the clock edge, the gate and mode pins act at once
  typedef struct packed {
    logic rst_pin;
    logic addr_latch_strobe;
    logic program_store_strobe_n;
    logic erase_select_pin;
    logic mode_ctrl_pin_b;
    logic mode_ctrl_pin_c;
    logic mode_ctrl_pin_d;
    logic chip_select_n;
    logic output_gate_n;
    pfp_vpp_t vpp;
  } pfp_ctrl_t;

  // table-read request from the core
  typedef struct packed {
    logic valid;
    logic from_internal;
    logic [15:0] addr;
  } pfp_tbl_req_t;

  // encoding applied to bytes leaving on port zero; replace freely
  function automatic logic [7:0] pfp_encrypt(input logic [7:0] data, input logic [15:0] addr);
    pfp_encrypt = data ^ PFP_CRYPT_KEY ^ addr[7:0];
  endfunction

endpackage

// ### logic/pfp_tbl_gate.sv
// module: routes core table reads to internal flash or external memory
`timescale 1ns/1ps
module pfp_tbl_gate
#(
  parameter int unsigned DEPTH = pfp_pkg::PFP_FLASH_DEPTH
)
(
  // request
  input wire pfp_pkg::pfp_tbl_req_t req,
  input wire logic tbl_restrict,
  // routing
  output logic to_internal,
  output logic to_external
);
  import pfp_pkg::*;

  logic in_range;
  logic allowed;

  // sized to the real array, so reads past it never wrap onto low cells
  assign in_range = (req.addr < PFP_ADDR_W'(DEPTH));
  // external code blocked; internal always allowed; no limit at one
  assign allowed = req.from_internal | tbl_restrict;
  assign to_internal = req.valid & in_range & allowed;
  assign to_external = req.valid & ~to_internal;

endmodule // pfp_tbl_gate
